// ==== include/pebu_pkg.sv ====
// package: opcodes, field layouts and request/response carriers for the pack/extend/bitfield unit
package pebu_pkg;

  // ==========================================================
  // operation codes
  typedef enum logic [4:0] {
    PEBU_OP_NOP        = 5'h00, // no operation
    PEBU_OP_PACK_BT    = 5'h01, // pack_bottom_top
    PEBU_OP_PACK_TB    = 5'h02, // pack_top_bottom
    PEBU_OP_SXT_B      = 5'h03, // signed_byte_extend
    PEBU_OP_SXT_H      = 5'h04, // signed_half_extend
    PEBU_OP_SXT_B16    = 5'h05, // signed_dual_byte_extend
    PEBU_OP_UXT_B      = 5'h06, // unsigned_byte_extend
    PEBU_OP_UXT_H      = 5'h07, // unsigned_half_extend
    PEBU_OP_UXT_B16    = 5'h08, // unsigned_dual_byte_extend
    PEBU_OP_SXTA_B     = 5'h09, // signed_byte_extend_add
    PEBU_OP_SXTA_H     = 5'h0a, // signed_half_extend_add
    PEBU_OP_SXTA_B16   = 5'h0b, // signed_dual_byte_extend_add
    PEBU_OP_UXTA_B     = 5'h0c, // unsigned_byte_extend_add
    PEBU_OP_UXTA_H     = 5'h0d, // unsigned_half_extend_add
    PEBU_OP_UXTA_B16   = 5'h0e, // unsigned_dual_byte_extend_add
    PEBU_OP_FLD_CLR    = 5'h0f, // field_clear
    PEBU_OP_FLD_INS    = 5'h10, // field_insert
    PEBU_OP_FLD_SXT    = 5'h11, // signed_field_extract
    PEBU_OP_FLD_UXT    = 5'h12  // unsigned_field_extract
  } pebu_op_t;

  // ==========================================================
  // widths and constants
  localparam int PEBU_DATA_W = 32; // datapath width
  localparam int PEBU_HALF_W = 16; // lane width
  localparam int PEBU_BYTE_W = 8; // byte width
  localparam int PEBU_SHAMT_W = 5; // shift immediate width
  localparam int PEBU_ROT_W = 2; // rotate select width
  localparam int PEBU_POS_W = 5; // field low position width
  localparam int PEBU_WID_W = 6; // field width, 1..32
  localparam logic [5:0] PEBU_ASR_FULL = 6'h20; // asr amount for encoded zero
  localparam logic [5:0] PEBU_FULL_W = 6'h20; // full word width
  localparam logic [31:0] PEBU_RESET_RESULT = 32'h0000_0000; // result after reset
  localparam int PEBU_LATENCY = 1; // cycles from request to result

  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid; // request strobe
    pebu_op_t op; // operation
    logic [31:0] first_operand; // first operand (also destination old value)
    logic [31:0] second_operand; // second operand
    logic [4:0] shift_amount; // pack shift immediate
    logic [1:0] rotate_sel; // rotate_right_select: 0,8,16,24
    logic [4:0] field_low_position; // bitfield low bit
    logic [5:0] field_width; // bitfield width
  } pebu_req_t;

  typedef struct packed {
    logic valid; // result strobe
    logic [31:0] result; // result word
  } pebu_rsp_t;

endpackage : pebu_pkg

// ==== src/pebu_lane_ext.sv ====
// lane extender: sign or zero extends a byte into a 16-bit lane and adds a lane addend
`timescale 1ns/100ps
module pebu_lane_ext
  import pebu_pkg::*;
(
  input wire logic [7:0] byte_in,
  input wire logic is_signed,
  input wire logic add_en,
  input wire logic [15:0] addend,
  output logic [15:0] lane_out
);

  // ==========================================================
  // extension and lane-local add
  logic [15:0] ext_lane; // extended byte

  // extend then wrap the sum inside the lane
  always_comb begin
    ext_lane = {{8{is_signed & byte_in[7]}}, byte_in};
    lane_out = add_en ? (ext_lane + addend) : ext_lane;
  end

endmodule : pebu_lane_ext

// ==== src/pebu_core.sv ====
// pack, extend and bitfield datapath unit with one registered result stage
`timescale 1ns/100ps
module pebu_core
  import pebu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pebu_req_t req,
  output pebu_rsp_t rsp_ff,
  output logic flags_write_ff
);

  // ==========================================================
  // pack datapath
  logic [31:0] lsl_val; // left-shifted second operand
  logic [5:0] asr_amt; // decoded right shift amount
  logic [31:0] asr_val; // arithmetic-shifted second operand
  logic [31:0] pack_bt; // bottom-top pack result
  logic [31:0] pack_tb; // top-bottom pack result

  // shift decode: zero left shift passes through, zero right shift is 32
  always_comb begin
    lsl_val = req.second_operand << req.shift_amount;
    asr_amt = (req.shift_amount == 5'h00) ? PEBU_ASR_FULL : {1'b0, req.shift_amount};
    asr_val = 32'($signed(req.second_operand) >>> asr_amt);
    pack_bt = {lsl_val[31:16], req.first_operand[15:0]};
    pack_tb = {req.first_operand[31:16], asr_val[15:0]};
  end

  // ==========================================================
  // extend datapath
  logic [31:0] rot_val; // rotated second operand
  logic ext_signed; // signed variant
  logic ext_add; // add variant
  logic [31:0] ext_byte; // byte extended to word
  logic [31:0] ext_half; // half extended to word
  logic [15:0] lane_lo; // dual low lane
  logic [15:0] lane_hi; // dual high lane

  // rotate right by byte multiples; select zero leaves value unrotated
  always_comb begin
    case (req.rotate_sel)
      2'h0: rot_val = req.second_operand;
      2'h1: rot_val = {req.second_operand[7:0], req.second_operand[31:8]};
      2'h2: rot_val = {req.second_operand[15:0], req.second_operand[31:16]};
      2'h3: rot_val = {req.second_operand[23:0], req.second_operand[31:24]};
      default: rot_val = req.second_operand;
    endcase
  end

  // variant decode
  always_comb begin
    case (req.op)
      PEBU_OP_SXT_B, PEBU_OP_SXT_H, PEBU_OP_SXT_B16,
      PEBU_OP_SXTA_B, PEBU_OP_SXTA_H, PEBU_OP_SXTA_B16: ext_signed = 1'b1;
      default: ext_signed = 1'b0;
    endcase
    case (req.op)
      PEBU_OP_SXTA_B, PEBU_OP_SXTA_H, PEBU_OP_SXTA_B16,
      PEBU_OP_UXTA_B, PEBU_OP_UXTA_H, PEBU_OP_UXTA_B16: ext_add = 1'b1;
      default: ext_add = 1'b0;
    endcase
  end

  // single byte and halfword extension
  always_comb begin
    ext_byte = {{24{ext_signed & rot_val[7]}}, rot_val[7:0]};
    ext_half = {{16{ext_signed & rot_val[15]}}, rot_val[15:0]};
  end

  // low lane from bits 7:0
  pebu_lane_ext u_lane_lo (
    .byte_in(rot_val[7:0]),
    .is_signed(ext_signed),
    .add_en(ext_add),
    .addend(req.first_operand[15:0]),
    .lane_out(lane_lo)
  );

  // high lane from bits 23:16
  pebu_lane_ext u_lane_hi (
    .byte_in(rot_val[23:16]),
    .is_signed(ext_signed),
    .add_en(ext_add),
    .addend(req.first_operand[31:16]),
    .lane_out(lane_hi)
  );

  // ==========================================================
  // bitfield datapath
  logic [31:0] ones_w; // width ones from bit 0
  logic [31:0] fld_mask; // field mask at position
  logic [31:0] fld_raw; // field shifted down
  logic [5:0] top_sh; // shift to place field msb at bit 31
  logic [31:0] fld_sext; // sign-extended field

  // build masks; width 32 gives all ones
  always_comb begin
    ones_w = (req.field_width >= PEBU_FULL_W) ? 32'hffff_ffff :
             ((32'h0000_0001 << req.field_width[4:0]) - 32'h0000_0001);
    fld_mask = ones_w << req.field_low_position;
    fld_raw = (req.second_operand >> req.field_low_position) & ones_w;
    top_sh = 6'(PEBU_FULL_W - req.field_width);
    fld_sext = 32'($signed(fld_raw << top_sh) >>> top_sh);
  end

  // ==========================================================
  // result select
  logic [31:0] nxt_result; // combinational result

  // operation mux; field clear and insert use first_operand as destination old value
  always_comb begin
    case (req.op)
      PEBU_OP_PACK_BT: nxt_result = pack_bt;
      PEBU_OP_PACK_TB: nxt_result = pack_tb;
      PEBU_OP_SXT_B, PEBU_OP_UXT_B: nxt_result = ext_byte;
      PEBU_OP_SXT_H, PEBU_OP_UXT_H: nxt_result = ext_half;
      PEBU_OP_SXT_B16, PEBU_OP_UXT_B16,
      PEBU_OP_SXTA_B16, PEBU_OP_UXTA_B16: nxt_result = {lane_hi, lane_lo};
      PEBU_OP_SXTA_B, PEBU_OP_UXTA_B: nxt_result = ext_byte + req.first_operand;
      PEBU_OP_SXTA_H, PEBU_OP_UXTA_H: nxt_result = ext_half + req.first_operand;
      PEBU_OP_FLD_CLR: nxt_result = req.first_operand & ~fld_mask;
      PEBU_OP_FLD_INS: nxt_result = (req.first_operand & ~fld_mask) |
                                    ((req.second_operand << req.field_low_position)
                                     & fld_mask);
      PEBU_OP_FLD_SXT: nxt_result = fld_sext;
      PEBU_OP_FLD_UXT: nxt_result = fld_raw;
      default: nxt_result = PEBU_RESET_RESULT;
    endcase
  end

  // ==========================================================
  // output registers
  // result stage: captured on each valid request
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rsp_ff <= '{valid: 1'b0, result: PEBU_RESET_RESULT};
    end else begin
      rsp_ff.valid <= req.valid;
      if (req.valid) begin
        rsp_ff.result <= nxt_result;
      end
    end
  end

  // flag write enable: none of these operations updates the flags
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags_write_ff <= 1'b0;
    end else begin
      flags_write_ff <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  sequence pack_bt_req_s;
    req.valid && req.op == PEBU_OP_PACK_BT;
  endsequence

  sequence ext_req_s;
    req.valid && req.op == PEBU_OP_UXT_B;
  endsequence

  pack_low_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pack_bt_req_s |=> rsp_ff.result[15:0] == $past(req.first_operand[15:0]))
    else $error("bottom-top pack low half wrong");

  pack_shift_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pack_bt_req_s |=> rsp_ff.result[31:16] ==
      $past(lsl_val[31:16]))
    else $error("bottom-top pack high half wrong");

  pack_top_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.valid && req.op == PEBU_OP_PACK_TB) |=>
      rsp_ff.result[31:16] == $past(req.first_operand[31:16]))
    else $error("top-bottom pack high half wrong");

  asr_full_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.valid && req.op == PEBU_OP_PACK_TB && req.shift_amount == 5'h00) |=>
      rsp_ff.result[15:0] == {16{$past(req.second_operand[31])}})
    else $error("top-bottom pack zero shift not 32");

  byte_zext_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ext_req_s and (req.rotate_sel == 2'h0)) |=>
      rsp_ff.result == {24'h000000, $past(req.second_operand[7:0])})
    else $error("unsigned byte extend wrong");

  flags_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    req.valid |-> ##[1:2] !flags_write_ff)
    else $error("flags written");

  field_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.valid && req.op == PEBU_OP_FLD_CLR) |=>
      (rsp_ff.result & $past(fld_mask)) == 32'h0000_0000 &&
      (rsp_ff.result & ~$past(fld_mask)) == ($past(req.first_operand) & ~$past(fld_mask)))
    else $error("field clear wrong");

  field_uext_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.valid && req.op == PEBU_OP_FLD_UXT && req.field_width == 6'h04) |=>
      rsp_ff.result[31:4] == 28'h0000000)
    else $error("unsigned extract not zero extended");

  valid_latency_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req.valid && req.op == PEBU_OP_UXTA_H) |=>
      rsp_ff.valid && rsp_ff.result ==
        $past(req.first_operand) + {16'h0000, $past(rot_val[15:0])})
    else $error("unsigned half extend add wrong");

endmodule : pebu_core

// ==== testbench/pebu_issue_model.sv ====
// issuing-side model: decode stage presenting requests to the unit
`timescale 1ns/100ps
module pebu_issue_model
  import pebu_pkg::*;
(
  input wire logic ref_clk,
  output pebu_req_t req
);
  // ==========================================================
  // request driver
  initial req = '0; // idle at time zero
  // present one request at a rising edge, field span kept legal
  task send(input pebu_req_t r);
    @(posedge ref_clk);
    if (r.field_width == 6'h00) begin
      r.field_width = 6'h01; // narrowest field
    end
    if (r.field_width > 6'h20 - r.field_low_position) begin
      r.field_width = 6'h20 - r.field_low_position; // clip to word top
    end
    req <= r;
  endtask : send
  // drop the strobe; stale operands are scrambled, not held
  task quiet;
    @(posedge ref_clk);
    req.valid <= 1'b0;
    req.first_operand <= ~req.first_operand;
    req.second_operand <= ~req.second_operand;
  endtask : quiet
endmodule : pebu_issue_model

// ==== testbench/tb.sv ====
// self-checking bench for the pack, extend and bitfield unit
`timescale 1ns/100ps
module tb;
  import pebu_pkg::*;
  logic ref_clk = 1'b0; // 20 MHz clock
  logic rst_n = 1'b0; // synchronous reset, active low
  pebu_req_t req; // request from the issue model
  pebu_rsp_t rsp_ff; // registered answer
  logic flags_write_ff; // flag write strobe
  int mismatches = 0;
  int comparisons = 0;
  // ==========================================================
  // clock and instances
  always #25 ref_clk = ~ref_clk;
  pebu_issue_model pebu_issue_model_inst (.ref_clk(ref_clk), .req(req));
  pebu_core pebu_core_inst (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rsp_ff(rsp_ff),
    .flags_write_ff(flags_write_ff));
  // ==========================================================
  // reference result worked out from the operation definitions
  function automatic logic [31:0] ref_res(input pebu_req_t r);
    logic [63:0] w;
    logic signed [63:0] s;
    logic [31:0] e;
    logic [31:0] m;
    logic [31:0] f;
    w = {r.second_operand, r.second_operand} >> (8 * r.rotate_sel);
    s = $signed({{32{r.second_operand[31]}}, r.second_operand}) >>>
      ((r.shift_amount == 5'h00) ? 32 : r.shift_amount);
    m = 32'hffff_ffff >> (32 - r.field_width);
    f = (r.second_operand >> r.field_low_position) & m;
    e = r.second_operand << r.shift_amount;
    case (r.op)
      PEBU_OP_PACK_BT: e = {e[31:16], r.first_operand[15:0]};
      PEBU_OP_PACK_TB: e = {r.first_operand[31:16], s[15:0]};
      PEBU_OP_SXT_B, PEBU_OP_SXTA_B: e = {{24{w[7]}}, w[7:0]};
      PEBU_OP_UXT_B, PEBU_OP_UXTA_B: e = {24'h0, w[7:0]};
      PEBU_OP_SXT_H, PEBU_OP_SXTA_H: e = {{16{w[15]}}, w[15:0]};
      PEBU_OP_UXT_H, PEBU_OP_UXTA_H: e = {16'h0, w[15:0]};
      PEBU_OP_SXT_B16, PEBU_OP_SXTA_B16: e = {{8{w[23]}}, w[23:16], {8{w[7]}}, w[7:0]};
      PEBU_OP_UXT_B16, PEBU_OP_UXTA_B16: e = {8'h0, w[23:16], 8'h0, w[7:0]};
      PEBU_OP_FLD_CLR: e = r.first_operand & ~(m << r.field_low_position);
      PEBU_OP_FLD_INS: e = (r.first_operand & ~(m << r.field_low_position)) |
        ((r.second_operand & m) << r.field_low_position);
      PEBU_OP_FLD_SXT: e = f[r.field_width - 1] ? (f | ~m) : f;
      PEBU_OP_FLD_UXT: e = f;
      default: e = 32'h0;
    endcase
    if (r.op inside {PEBU_OP_SXTA_B16, PEBU_OP_UXTA_B16}) begin // lanes wrap apart
      e = {e[31:16] + r.first_operand[31:16], e[15:0] + r.first_operand[15:0]};
    end else if (r.op inside {PEBU_OP_SXTA_B, PEBU_OP_SXTA_H, PEBU_OP_UXTA_B, PEBU_OP_UXTA_H}) begin
      e = e + r.first_operand;
    end
    return e;
  endfunction : ref_res
  // ==========================================================
  // shared checks
  task expect_rsp(input logic v, input logic [31:0] exp);
    comparisons++;
    if (rsp_ff.valid !== v || rsp_ff.result !== exp || flags_write_ff !== 1'b0) begin
      mismatches++;
      $display("Error at %0t: got %b %h %b, expected %b %h", $time, rsp_ff.valid,
        rsp_ff.result, flags_write_ff, v, exp);
    end
  endtask : expect_rsp
  // one request, answer judged one cycle after it is presented
  task check_op(input pebu_op_t op, input logic [31:0] a, input logic [31:0] b,
    input logic [4:0] sh, input logic [1:0] rot, input logic [4:0] pos, input logic [5:0] wid);
    pebu_req_t r;
    r = '{1'b1, op, a, b, sh, rot, pos, wid};
    pebu_issue_model_inst.send(r);
    pebu_issue_model_inst.quiet();
    #1;
    expect_rsp(1'b1, ref_res(r));
  endtask : check_op
  // ==========================================================
  // scenarios
  task test_reset;
    repeat (3) @(posedge ref_clk);
    #1;
    expect_rsp(1'b0, PEBU_RESET_RESULT);
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask : test_reset
  task test_pack;
    check_op(PEBU_OP_PACK_BT, 32'h1234_5678, 32'h8765_4321, 5'h00, 2'h0, 5'h0, 6'h1);
    check_op(PEBU_OP_PACK_BT, 32'h1234_5678, 32'h8765_4321, 5'h1f, 2'h0, 5'h0, 6'h1);
    check_op(PEBU_OP_PACK_BT, 32'hcafe_0001, 32'h0abc_def1, 5'h04, 2'h0, 5'h0, 6'h1);
    check_op(PEBU_OP_PACK_TB, 32'h1234_5678, 32'h8000_1234, 5'h00, 2'h0, 5'h0, 6'h1);
    check_op(PEBU_OP_PACK_TB, 32'h1234_5678, 32'h8765_4321, 5'h01, 2'h0, 5'h0, 6'h1);
    check_op(PEBU_OP_PACK_TB, 32'hbeef_0000, 32'h7fff_0000, 5'h10, 2'h0, 5'h0, 6'h1);
  endtask : test_pack
  // every extend and extend-add code under every rotation
  task test_extend;
    for (int o = 3; o <= 14; o++) begin
      for (int k = 0; k < 4; k++) begin
        check_op(pebu_op_t'(o), 32'h7fff_ffff, 32'h80ff_7f81, 5'h0, k[1:0], 5'h0, 6'h1);
      end
    end
  endtask : test_extend
  // field codes at edge positions and widths
  task test_field;
    logic [4:0] pos[4];
    logic [5:0] wid[4];
    pos = '{5'd8, 5'd0, 5'd31, 5'd4};
    wid = '{6'd12, 6'd32, 6'd1, 6'd3};
    for (int o = 15; o <= 18; o++) begin
      for (int k = 0; k < 4; k++) begin
        check_op(pebu_op_t'(o), 32'h5a5a_a5a5, 32'hcab8_9e3c, 5'h0, 2'h0, pos[k], wid[k]);
      end
    end
  endtask : test_field
  // two requests on consecutive edges, then the result must hold
  task test_back_to_back;
    pebu_req_t r1;
    pebu_req_t r2;
    r1 = '{1'b1, PEBU_OP_UXTA_B16, 32'hffff_8001, 32'h00ff_00ff, 5'h0, 2'h0, 5'h0, 6'h1};
    r2 = '{1'b1, PEBU_OP_FLD_INS, 32'hffff_ffff, 32'h0000_0000, 5'h0, 2'h0, 5'h8, 6'hc};
    pebu_issue_model_inst.send(r1);
    pebu_issue_model_inst.send(r2);
    #1;
    expect_rsp(1'b1, ref_res(r1));
    pebu_issue_model_inst.quiet();
    #1;
    expect_rsp(1'b1, ref_res(r2));
    @(posedge ref_clk);
    #1;
    expect_rsp(1'b0, ref_res(r2));
  endtask : test_back_to_back
  // ==========================================================
  // verdict and run control
  task finish_test;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    test_reset();
    test_pack();
    test_extend();
    test_field();
    test_back_to_back();
    finish_test();
  end
  // hang guard
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    $display("Error at %0t: run timed out", $time);
    finish_test();
  end
endmodule : tb
